// ==== design/rbs_exec.sv ====
// Functional notes
// - Port-D clear drives bit selected by Y low; only Y 0..7 valid.
// - Subroutine return pops PC from stack, decrements SP, two cycles.
// - Interrupt return pops PC, decrements SP, resumes main, one cycle.
// - Interrupt return restores file, row and word data pointers.
// - Interrupt return restores carry, skip status and no-op mode status.
// - No-op status covers repeated load-immediate runs executing only first.
// - Interrupt return restores accumulator A and register B.
// - Return-and-skip pops like return, two cycles, skips next instruction.
// - Memory bit set writes 1 to bit j of nibble at data pointer.
`timescale 1ns/10ps
module rbs_exec #(
  parameter int STACK_D = rbs_pkg::RBS_STACK_D
) (
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           rst_b,
  // Decoded instruction
  input  wire logic                           instr_valid,
  input  wire rbs_pkg::rbs_op_e               instr_op,
  input  wire logic [1:0]                     bit_j,
  input  wire logic                           load_imm_instr,
  input  wire logic [rbs_pkg::RBS_PC_W-1:0]   pc_in,
  // Interrupt entry and live context
  input  wire logic                           int_take,
  input  wire rbs_pkg::rbs_ctx_s              live_ctx,
  // Data memory read side
  input  wire logic [3:0]                     mem_rdata,
  // High-reference flag set from elsewhere in the core
  input  wire logic                           high_ref_set,
  // Program flow
  output logic                                busy,
  output logic                                pc_load,
  output logic [rbs_pkg::RBS_PC_W-1:0]        pc_out,
  output logic                                skip_next,
  output logic [rbs_pkg::RBS_SP_W-1:0]        stack_ptr,
  // Context restore
  output logic                                ctx_restore,
  output rbs_pkg::rbs_ctx_s                   ctx_out,
  output logic                                nop_mode,
  // Data memory write
  output logic                                mem_we,
  output logic [rbs_pkg::RBS_DADDR_W-1:0]     mem_addr,
  output logic [3:0]                          mem_wdata,
  // Flags and ports
  output logic                                carry_flag,
  output logic                                high_ref_enable_flag,
  output logic                                port_c,
  output logic [rbs_pkg::RBS_PORTD_W-1:0]     port_d
);
  import rbs_pkg::*;

  rbs_state_e         state_reg, state_next;
  rbs_ctx_s           saved_reg;
  logic               busy_reg, pc_load_reg, skip_reg, restore_reg;
  logic [RBS_PC_W-1:0] pc_reg;
  logic               mem_we_reg;
  logic [RBS_DADDR_W-1:0] mem_addr_reg;
  logic [3:0]         mem_wdata_reg;
  logic               carry_reg, high_ref_reg, portc_reg, nop_reg;
  rbs_ctx_s           ctx_snap;
  logic [RBS_PORTD_W-1:0] portd_reg;
  rbs_ctx_s           ctx_reg;
  logic [RBS_SP_W-1:0] sp_reg;

  wire go = instr_valid && !busy_reg;
  wire is_ret   = go && (instr_op == RBS_OP_RET);
  wire is_retsk = go && (instr_op == RBS_OP_RETSK);
  wire is_reti  = go && (instr_op == RBS_OP_RETI);
  wire is_clrd  = go && (instr_op == RBS_OP_CLRD);
  wire is_setb  = go && (instr_op == RBS_OP_SETB);
  wire is_setc  = go && (instr_op == RBS_OP_SETC);
  wire is_setpc = go && (instr_op == RBS_OP_SETPC);
  wire is_clrup = go && (instr_op == RBS_OP_CLRUP);
  wire pop      = is_ret || is_retsk || is_reti;
  wire y_ok     = (live_ctx.row_y <= RBS_PORTD_MAX);
  wire [2:0] y_idx = live_ctx.row_y[2:0];
  wire [RBS_PORTD_W-1:0] d_mask = ~(8'h01 << y_idx);
  wire [3:0] set_mask = 4'h1 << bit_j;
  wire [RBS_DADDR_W-1:0] ptr_addr =
    {live_ctx.file_x, live_ctx.row_y, live_ctx.word_z};
  wire [RBS_PC_W-1:0] stk_top;
  wire [RBS_SP_W-1:0] stk_sp;
  // Mirrors the stack: interrupt entry pushes, returns pop
  wire [RBS_SP_W-1:0] sp_next = int_take ? stk_sp + RBS_SP_W'(1) :
                                pop ? stk_sp - RBS_SP_W'(1) : stk_sp;
  // Run of load-immediates: only the first executes
  wire nop_next = go ? load_imm_instr : nop_reg;
  wire nop_sel  = is_reti ? saved_reg.nop_mode : nop_next;
  wire carry_sel = is_reti ? saved_reg.carry :
                   is_setc ? 1'b1 : carry_reg;

  rbs_ret_stack #(
    .DEPTH (STACK_D),
    .PC_W  (RBS_PC_W),
    .SP_W  (RBS_SP_W)
  ) u_stack (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .push    (int_take),
    .push_pc (pc_in),
    .pop     (pop),
    .top_pc  (stk_top),
    .sp      (stk_sp)
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RBS_ST_IDLE: begin
        if (is_ret || is_retsk) begin
          state_next = RBS_ST_RET2;
        end
      end
      RBS_ST_RET2: begin
        state_next = RBS_ST_IDLE;
      end
      default: state_next = RBS_ST_IDLE;
    endcase
  end

  // Carry and no-op status live here, so they are saved from here
  always_comb begin
    ctx_snap          = live_ctx;
    ctx_snap.carry    = carry_reg;
    ctx_snap.nop_mode = nop_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      saved_reg <= '0;
    end else if (int_take) begin
      saved_reg <= ctx_snap;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg     <= RBS_ST_IDLE;
      busy_reg      <= 1'b0;
      pc_load_reg   <= 1'b0;
      pc_reg        <= '0;
      skip_reg      <= 1'b0;
      restore_reg   <= 1'b0;
      ctx_reg       <= '0;
      nop_reg       <= 1'b0;
      sp_reg        <= RBS_SP_RST;
    end else begin
      state_reg   <= state_next;
      busy_reg    <= (state_next == RBS_ST_RET2);
      pc_load_reg <= pop;
      if (pop) begin
        pc_reg <= stk_top;
      end
      skip_reg    <= is_retsk ? 1'b1 :
                     is_reti  ? saved_reg.skip : 1'b0;
      restore_reg <= is_reti;
      if (is_reti) begin
        ctx_reg <= saved_reg;
      end
      nop_reg <= nop_sel;
      sp_reg  <= sp_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      mem_we_reg    <= 1'b0;
      mem_addr_reg  <= '0;
      mem_wdata_reg <= RBS_NIB_RST;
      carry_reg     <= 1'b0;
      high_ref_reg  <= 1'b0;
      portc_reg     <= RBS_PORTC_RST;
      portd_reg     <= RBS_PORTD_RST;
    end else begin
      mem_we_reg <= is_setb;
      if (is_setb) begin
        mem_addr_reg  <= ptr_addr;
        mem_wdata_reg <= mem_rdata | set_mask;
      end
      carry_reg <= carry_sel;
      // A set from the core wins over a clear in the same cycle
      if (high_ref_set) begin
        high_ref_reg <= 1'b1;
      end else if (is_clrup) begin
        high_ref_reg <= 1'b0;
      end
      if (is_setpc) begin
        portc_reg <= 1'b1;
      end
      if (is_clrd && y_ok) begin
        portd_reg <= portd_reg & d_mask;
      end
    end
  end

  assign busy                 = busy_reg;
  assign pc_load              = pc_load_reg;
  assign pc_out               = pc_reg;
  assign skip_next            = skip_reg;
  assign stack_ptr            = sp_reg;
  assign ctx_restore          = restore_reg;
  assign ctx_out              = ctx_reg;
  assign nop_mode             = nop_reg;
  assign mem_we               = mem_we_reg;
  assign mem_addr             = mem_addr_reg;
  assign mem_wdata            = mem_wdata_reg;
  assign carry_flag           = carry_reg;
  assign high_ref_enable_flag = high_ref_reg;
  assign port_c               = portc_reg;
  assign port_d               = portd_reg;

  property p_ret_two;
    @(posedge sys_clk) disable iff (!rst_b)
      is_ret |=> busy ##1 !busy;
  endproperty
  a_ret_two: assert property (p_ret_two)
    else $error("return not 2 cycles");

  property p_reti_one;
    @(posedge sys_clk) disable iff (!rst_b)
      is_reti |=> pc_load && !busy && ctx_restore;
  endproperty
  a_reti_one: assert property (p_reti_one)
    else $error("reti not 1 cycle");

  property p_reti_ctx;
    @(posedge sys_clk) disable iff (!rst_b)
      is_reti |=> ctx_out == $past(saved_reg);
  endproperty
  a_reti_ctx: assert property (p_reti_ctx)
    else $error("pointers lost");

  property p_reti_carry;
    @(posedge sys_clk) disable iff (!rst_b)
      is_reti |=> carry_flag == $past(saved_reg.carry);
  endproperty
  a_reti_carry: assert property (p_reti_carry)
    else $error("carry lost");

  property p_reti_nop;
    @(posedge sys_clk) disable iff (!rst_b)
      is_reti |=> nop_mode == $past(saved_reg.nop_mode);
  endproperty
  a_reti_nop: assert property (p_reti_nop)
    else $error("nop mode lost");

  property p_reti_ab;
    @(posedge sys_clk) disable iff (!rst_b)
      is_reti |=> ctx_out.acc_a == $past(saved_reg.acc_a)
              && ctx_out.reg_b == $past(saved_reg.reg_b);
  endproperty
  a_reti_ab: assert property (p_reti_ab)
    else $error("A or B lost");

  property p_retsk;
    @(posedge sys_clk) disable iff (!rst_b)
      is_retsk |=> skip_next && pc_load && pc_out == $past(stk_top);
  endproperty
  a_retsk: assert property (p_retsk)
    else $error("ret-skip wrong");

  property p_setb;
    @(posedge sys_clk) disable iff (!rst_b)
      is_setb |=> mem_we && mem_wdata[$past(bit_j)];
  endproperty
  a_setb: assert property (p_setb)
    else $error("bit set missed");

  property p_setc;
    @(posedge sys_clk) disable iff (!rst_b)
      is_setc |=> carry_flag;
  endproperty
  a_setc: assert property (p_setc)
    else $error("carry not set");

  property p_setpc;
    @(posedge sys_clk) disable iff (!rst_b)
      is_setpc |=> port_c;
  endproperty
  a_setpc: assert property (p_setpc)
    else $error("port C not set");

  property p_clrup;
    @(posedge sys_clk) disable iff (!rst_b)
      is_clrup && !high_ref_set |=>
        !high_ref_enable_flag && $stable(carry_flag);
  endproperty
  a_clrup: assert property (p_clrup)
    else $error("flag clear wrong");

  property p_clrd;
    @(posedge sys_clk) disable iff (!rst_b)
      is_clrd && y_ok |=> !port_d[$past(y_idx)];
  endproperty
  a_clrd: assert property (p_clrd)
    else $error("port D bit not cleared");

endmodule : rbs_exec

// ==== shared/rbs_pkg.sv ====
package rbs_pkg;

  localparam int RBS_PC_W    = 14;
  localparam int RBS_SP_W    = 3;
  localparam int RBS_STACK_D = 8;
  localparam int RBS_PORTD_W = 8;
  localparam int RBS_DADDR_W = 10;

  // Cycle counts per instruction
  localparam int RBS_RET_CYCLES  = 2;
  localparam int RBS_RTI_CYCLES  = 1;

  // Reset values
  localparam logic [RBS_SP_W-1:0] RBS_SP_RST = 3'h7;
  localparam logic [7:0] RBS_PORTD_RST = 8'hff;
  localparam logic       RBS_PORTC_RST = 1'b0;
  localparam logic [3:0] RBS_NIB_RST   = 4'h0;

  // Index limit for the port D bit pointer
  localparam logic [3:0] RBS_PORTD_MAX = 4'h7;

  typedef enum logic [3:0] {
    RBS_OP_NONE   = 4'h0,
    RBS_OP_CLRD   = 4'h1,
    RBS_OP_RET    = 4'h2,
    RBS_OP_RETI   = 4'h3,
    RBS_OP_RETSK  = 4'h4,
    RBS_OP_SETB   = 4'h5,
    RBS_OP_SETC   = 4'h6,
    RBS_OP_SETPC  = 4'h7,
    RBS_OP_CLRUP  = 4'h8
  } rbs_op_e;

  // Context saved on interrupt entry
  typedef struct packed {
    logic [2:0] file_x;
    logic [3:0] row_y;
    logic [2:0] word_z;
    logic       carry;
    logic       skip;
    logic       nop_mode;
    logic [3:0] acc_a;
    logic [3:0] reg_b;
  } rbs_ctx_s;

  typedef enum logic [1:0] {
    RBS_ST_IDLE = 2'b00,
    RBS_ST_RET2 = 2'b01
  } rbs_state_e;

endpackage : rbs_pkg

// ==== design/rbs_ret_stack.sv ====
`timescale 1ns/10ps
module rbs_ret_stack #(
  parameter int DEPTH = 8,
  parameter int PC_W  = 14,
  parameter int SP_W  = 3
) (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  // Push and pop
  input  wire logic            push,
  input  wire logic [PC_W-1:0] push_pc,
  input  wire logic            pop,
  output logic      [PC_W-1:0] top_pc,
  output logic      [SP_W-1:0] sp
);
  import rbs_pkg::*;

  logic [PC_W-1:0] mem_reg [DEPTH];
  logic [SP_W-1:0] sp_reg;
  logic [SP_W-1:0] sp_inc;

  assign sp_inc = sp_reg + SP_W'(1);
  assign top_pc = mem_reg[sp_reg];
  assign sp     = sp_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sp_reg <= SP_W'(RBS_SP_RST);
      // Cleared so a pop from an empty stack returns a known PC
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (push) begin
      sp_reg          <= sp_inc;
      mem_reg[sp_inc] <= push_pc;
    end else if (pop) begin
      sp_reg <= sp_reg - SP_W'(1);
    end
  end

endmodule : rbs_ret_stack

// ==== test/rbs_exec_test.sv ====
`timescale 1ns/10ps
module rbs_exec_test;
  import rbs_pkg::*;
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end

  logic                  sys_clk;
  logic                  rst_b;
  logic                  instr_valid;
  rbs_op_e               instr_op;
  logic [1:0]            bit_j;
  logic                  load_imm_instr;
  logic [RBS_PC_W-1:0]   pc_in;
  logic                  int_take;
  rbs_ctx_s              live_ctx;
  logic [3:0]            mem_rdata;
  logic                  high_ref_set;
  logic                  busy;
  logic                  pc_load;
  logic [RBS_PC_W-1:0]   pc_out;
  logic                  skip_next;
  logic [RBS_SP_W-1:0]   stack_ptr;
  logic                  ctx_restore;
  rbs_ctx_s              ctx_out;
  logic                  nop_mode;
  logic                  mem_we;
  logic [RBS_DADDR_W-1:0] mem_addr;
  logic [3:0]            mem_wdata;
  logic                  carry_flag;
  logic                  high_ref_enable_flag;
  logic                  port_c;
  logic [RBS_PORTD_W-1:0] port_d;
  int                    n_fail;
  int                    cmp_count;
  int                    cycles;
  rbs_ctx_s              saved;

  rbs_exec i_rbs_exec (.sys_clk(sys_clk), .rst_b(rst_b),
    .instr_valid(instr_valid), .instr_op(instr_op), .bit_j(bit_j),
    .load_imm_instr(load_imm_instr), .pc_in(pc_in), .int_take(int_take),
    .live_ctx(live_ctx), .mem_rdata(mem_rdata), .high_ref_set(high_ref_set),
    .busy(busy),
    .pc_load(pc_load), .pc_out(pc_out), .skip_next(skip_next),
    .stack_ptr(stack_ptr), .ctx_restore(ctx_restore), .ctx_out(ctx_out),
    .nop_mode(nop_mode), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .carry_flag(carry_flag),
    .high_ref_enable_flag(high_ref_enable_flag), .port_c(port_c),
    .port_d(port_d));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic complete_run;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // Present an op; returns at the next falling edge, whether or not that cycle takes it
  task automatic issue(input rbs_op_e op);
    instr_op    = op;
    instr_valid = 1'b1;
    @(negedge sys_clk);
  endtask : issue

  task automatic idle;
    instr_valid = 1'b0;
    instr_op    = RBS_OP_NONE;
    @(negedge sys_clk);
  endtask : idle

  task automatic t_clrd;
    live_ctx.row_y = 4'h3;
    issue(RBS_OP_CLRD);
    `CHK(port_d, 8'hf7)
    live_ctx.row_y = 4'h8;
    issue(RBS_OP_CLRD);
    `CHK(port_d, 8'hf7)
    live_ctx.row_y = 4'h7;
    issue(RBS_OP_CLRD);
    `CHK(port_d, 8'h77)
    idle();
  endtask : t_clrd

  task automatic t_ret;
    issue(RBS_OP_RET);
    `CHK(pc_load, 1'b1)
    `CHK(busy, 1'b1)
    `CHK(stack_ptr, 3'h6)
    // Carry set offered in the busy cycle must be dropped
    issue(RBS_OP_SETC);
    `CHK(busy, 1'b0)
    `CHK(pc_load, 1'b0)
    `CHK(carry_flag, 1'b0)
    idle();
  endtask : t_ret

  task automatic t_retsk;
    issue(RBS_OP_RETSK);
    `CHK(pc_load, 1'b1)
    `CHK(skip_next, 1'b1)
    `CHK(busy, 1'b1)
    `CHK(stack_ptr, 3'h5)
    idle();
    `CHK(busy, 1'b0)
  endtask : t_retsk

  task automatic t_setb;
    live_ctx.file_x = 3'h5;
    live_ctx.row_y  = 4'ha;
    live_ctx.word_z = 3'h2;
    mem_rdata       = 4'h2;
    for (int j = 0; j < 4; j++) begin
      bit_j = 2'(j);
      issue(RBS_OP_SETB);
      `CHK(mem_we, 1'b1)
      `CHK(mem_wdata, 4'h2 | (4'h1 << j))
      `CHK(mem_addr, {3'h5, 4'ha, 3'h2})
      idle();
      `CHK(mem_we, 1'b0)
    end
  endtask : t_setb

  task automatic t_flags;
    high_ref_set = 1'b1;
    issue(RBS_OP_SETC);
    `CHK(carry_flag, 1'b1)
    `CHK(high_ref_enable_flag, 1'b1)
    high_ref_set = 1'b0;
    issue(RBS_OP_CLRUP);
    `CHK(high_ref_enable_flag, 1'b0)
    `CHK(carry_flag, 1'b1)
    // Set and clear together: the set wins
    high_ref_set = 1'b1;
    issue(RBS_OP_CLRUP);
    `CHK(high_ref_enable_flag, 1'b1)
    high_ref_set = 1'b0;
    issue(RBS_OP_SETPC);
    `CHK(port_c, 1'b1)
    `CHK(high_ref_enable_flag, 1'b1)
    idle();
  endtask : t_flags

  task automatic t_reti;
    // Mid-run reset clears carry so that its restore can be seen
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK(port_d, RBS_PORTD_RST)
    `CHK(stack_ptr, RBS_SP_RST)
    `CHK({port_c, carry_flag, high_ref_enable_flag}, 3'h0)
    rst_b    = 1'b1;
    saved    = {3'h1, 4'h2, 3'h3, 1'b0, 1'b1, 1'b0, 4'h9, 4'h6};
    live_ctx = saved;
    pc_in    = 14'h2a5c;
    int_take = 1'b1;
    @(negedge sys_clk);
    int_take       = 1'b0;
    live_ctx       = ~saved;
    pc_in          = '0;
    load_imm_instr = 1'b1;
    issue(RBS_OP_SETC);
    `CHK(nop_mode, 1'b1)
    `CHK(carry_flag, 1'b1)
    `CHK(stack_ptr, 3'h0)
    load_imm_instr = 1'b0;
    issue(RBS_OP_RETI);
    `CHK(ctx_restore, 1'b1)
    `CHK(pc_load, 1'b1)
    `CHK(pc_out, 14'h2a5c)
    `CHK(busy, 1'b0)
    `CHK(stack_ptr, 3'h7)
    `CHK({ctx_out.file_x, ctx_out.row_y, ctx_out.word_z}, 10'h093)
    `CHK(carry_flag, 1'b0)
    `CHK(skip_next, 1'b1)
    `CHK(nop_mode, 1'b0)
    `CHK({ctx_out.acc_a, ctx_out.reg_b}, 8'h96)
    idle();
  endtask : t_reti

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    n_fail = 0;
    cmp_count = 0;
    cycles = 0;
    rst_b = 1'b0;
    instr_valid = 1'b0;
    instr_op = RBS_OP_NONE;
    bit_j = 2'h0;
    load_imm_instr = 1'b0;
    pc_in = '0;
    int_take = 1'b0;
    live_ctx = '0;
    mem_rdata = 4'h0;
    high_ref_set = 1'b0;
    repeat (12) @(negedge sys_clk);
    `CHK(port_d, RBS_PORTD_RST)
    `CHK(stack_ptr, RBS_SP_RST)
    `CHK({port_c, carry_flag, busy}, 3'h0)
    rst_b = 1'b1;
    t_clrd();
    t_ret();
    t_retsk();
    t_setb();
    t_flags();
    t_reti();
    complete_run();
  end
endmodule : rbs_exec_test
